// ===== core/breakpoint_request_pkg.sv
// package: register map, field positions and types for the breakpoint unit
package bamu_pkg;
    localparam logic [11:0] OFS_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_ADDR_HIGH = 12'h004;
    localparam logic [11:0] OFS_ADDR_LOW = 12'h008;
    localparam logic [11:0] OFS_AUXILIARY = 12'h00C;
    localparam logic [11:0] OFS_WAIT_STATUS = 12'h010;
    localparam logic [11:0] OFS_FLAG_CONTROL = 12'h014;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h018;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h01C;
    localparam int BIT_MATCH_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_WDOG_HOLD = 0;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_FLAG_CLEAR = 7;
    localparam int IRQ_BIT_MATCH = 0;
    localparam int IRQ_BIT_SOFT = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_IRQ = 2'h0;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // cpu-side signals that travel together
    typedef struct packed {
        logic [15:0] addr;
        logic fetch;
        logic opcode;
        logic insn_start;
    } bamu_cpu_t;

    typedef struct packed {
        logic in_wait;
        logic in_stop;
        logic monitor_mode;
        logic wait_exit;
        logic rti;
    } bamu_sys_t;

    typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_BREAK} bamu_state_t;
endpackage

// ===== core/breakpoint_request_unit.sv
// breakpoint address match unit with apb register access
//
// Overview of operation
// - enabled full 16-bit address match requests break
// - match enable at bit 7, reset clear
// - hardware sets active bit on address match
// - writing one to active bit forces break
// - forced break taken before next instruction
// - opcode match breaks before instruction executes
// - operand match breaks after instruction completes
// - unchanged address after clear in break blocks repeat break
// - active bit cleared by zero write, reset
// - two byte address registers, reset to zero
// - timer counter halted during break
// - watchdog hold in break in monitor mode
// - flag clearing in break needs enable bit
// - wait exit flag shows break-caused wait exit
// - no match break in wait or stop
// - match asserts breakpoint request to integration unit
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
module bamu_unit
    import bamu_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu and integration unit
    input wire bamu_cpu_t cpu,
    input wire bamu_sys_t sys,
    output logic breakpoint_request,
    output logic in_break,
    // controls to other modules
    output logic timer_halt,
    output logic watchdog_hold,
    output logic flag_clear_allowed,
    // interrupt
    output logic irq
);
    logic [7:0] break_address_high_r;
    logic [7:0] break_address_low_r;
    logic match_break_enable_r;
    logic break_active_flag_r;
    logic watchdog_hold_in_break_r;
    logic wait_exit_by_break_r;
    logic flag_clear_in_break_enable_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_mask_r;
    logic match_armed_r;
    logic [31:0] prdata_r;
    bamu_state_t state_r;
    bamu_state_t state_nxt;

    logic wr_en;
    logic rd_en;
    logic mapped;
    logic addr_hit;
    logic match_opcode;
    logic match_operand;
    logic soft_break;
    logic addr_write;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == OFS_STATUS_CONTROL) || (paddr == OFS_ADDR_HIGH)
        || (paddr == OFS_ADDR_LOW) || (paddr == OFS_AUXILIARY)
        || (paddr == OFS_WAIT_STATUS) || (paddr == OFS_FLAG_CONTROL)
        || (paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_MASK);
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;

    // only fetches count, and a bus frozen in wait/stop cannot match
    assign addr_hit = match_break_enable_r && match_armed_r && cpu.fetch
        && !sys.in_wait && !sys.in_stop
        && (cpu.addr == {break_address_high_r, break_address_low_r});
    assign match_opcode = addr_hit && cpu.opcode;
    assign match_operand = addr_hit && !cpu.opcode;
    assign soft_break = wr_en && (paddr == OFS_STATUS_CONTROL)
        && pwdata[BIT_ACTIVE];
    assign addr_write = wr_en && ((paddr == OFS_ADDR_HIGH) || (paddr == OFS_ADDR_LOW));

    // break sequencing: opcode match breaks at once, operand or soft waits
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (match_opcode)
                    state_nxt = ST_BREAK;
                else if (match_operand || soft_break)
                    state_nxt = ST_PEND;
            end
            ST_PEND:
            begin
                if (cpu.insn_start || match_opcode)
                    state_nxt = ST_BREAK;
            end
            ST_BREAK:
            begin
                if (sys.rti)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // request pulses for one cycle, in the cycle before the state enters ST_BREAK, then the sw vector runs
    assign breakpoint_request = (state_r == ST_IDLE && match_opcode)
        || (state_r == ST_PEND && (cpu.insn_start || match_opcode));
    assign in_break = (state_r == ST_BREAK);
    assign timer_halt = in_break;
    assign watchdog_hold = in_break && sys.monitor_mode && watchdog_hold_in_break_r;
    assign flag_clear_allowed = !in_break || flag_clear_in_break_enable_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_break_enable_r <= 1'b0;
            break_active_flag_r <= 1'b0;
        end
        else
        begin
            if (wr_en && paddr == OFS_STATUS_CONTROL)
            begin
                match_break_enable_r <= pwdata[BIT_MATCH_ENABLE];
                break_active_flag_r <= pwdata[BIT_ACTIVE];
            end
            // set wins over a simultaneous zero write
            if (addr_hit)
                break_active_flag_r <= 1'b1;
        end
    end

    // clearing the flag in break without moving the address disarms the match
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_armed_r <= 1'b1;
        else if (addr_write)
            match_armed_r <= 1'b1;
        else if (wr_en && paddr == OFS_STATUS_CONTROL && !pwdata[BIT_ACTIVE]
                 && in_break)
            match_armed_r <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            break_address_high_r <= RESET_BYTE;
            break_address_low_r <= RESET_BYTE;
            watchdog_hold_in_break_r <= 1'b0;
            flag_clear_in_break_enable_r <= 1'b0;
            irq_mask_r <= RESET_IRQ;
        end
        else if (wr_en)
        begin
            if (paddr == OFS_ADDR_HIGH)
                break_address_high_r <= pwdata[7:0];
            else if (paddr == OFS_ADDR_LOW)
                break_address_low_r <= pwdata[7:0];
            else if (paddr == OFS_AUXILIARY)
                watchdog_hold_in_break_r <= pwdata[BIT_WDOG_HOLD];
            else if (paddr == OFS_FLAG_CONTROL)
                flag_clear_in_break_enable_r <= pwdata[BIT_FLAG_CLEAR];
            else if (paddr == OFS_IRQ_MASK)
                irq_mask_r <= pwdata[1:0];
        end
    end

    // wait-exit flag: latched on wait exit while entering or in break, cleared on rti in break or on a wait exit outside break
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wait_exit_by_break_r <= 1'b0;
        else if (sys.wait_exit && (breakpoint_request || in_break))
            wait_exit_by_break_r <= 1'b1;
        else if (sys.wait_exit || (in_break && sys.rti))
            wait_exit_by_break_r <= 1'b0;
    end

    // sticky events, write one to clear, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status_r <= RESET_IRQ;
        else
        begin
            // in break a clear needs the flag-clear enable, so a debugger loses no events
            if (wr_en && paddr == OFS_IRQ_STATUS && flag_clear_allowed)
                irq_status_r <= irq_status_r & ~pwdata[1:0];
            if (addr_hit)
                irq_status_r[IRQ_BIT_MATCH] <= 1'b1;
            if (soft_break)
                irq_status_r[IRQ_BIT_SOFT] <= 1'b1;
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    // read data registered in the setup cycle, valid in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= RD_UNMAPPED;
        else if (psel && !penable && !pwrite)
        begin
            prdata_r <= RD_UNMAPPED;
            if (paddr == OFS_STATUS_CONTROL)
            begin
                prdata_r[BIT_MATCH_ENABLE] <= match_break_enable_r;
                prdata_r[BIT_ACTIVE] <= break_active_flag_r;
            end
            else if (paddr == OFS_ADDR_HIGH)
                prdata_r[7:0] <= break_address_high_r;
            else if (paddr == OFS_ADDR_LOW)
                prdata_r[7:0] <= break_address_low_r;
            else if (paddr == OFS_AUXILIARY)
                prdata_r[BIT_WDOG_HOLD] <= watchdog_hold_in_break_r;
            else if (paddr == OFS_WAIT_STATUS)
                prdata_r[BIT_WAIT_EXIT] <= wait_exit_by_break_r;
            else if (paddr == OFS_FLAG_CONTROL)
                prdata_r[BIT_FLAG_CLEAR] <= flag_clear_in_break_enable_r;
            else if (paddr == OFS_IRQ_STATUS)
                prdata_r[1:0] <= irq_status_r;
            else if (paddr == OFS_IRQ_MASK)
                prdata_r[1:0] <= irq_mask_r;
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;

    // properties tie break sequencing and register behaviour to the rules
    property p_match_request;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && match_opcode) |-> breakpoint_request ##1 in_break;
    endproperty
    a_match_request: assert property (p_match_request) else $error("opcode match no break");

    property p_enable_gate;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && !match_break_enable_r && !soft_break) |=> state_r == ST_IDLE;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("match while disabled");

    property p_active_set;
        @(posedge pclk) disable iff (!presetn)
        addr_hit |=> break_active_flag_r;
    endproperty
    a_active_set: assert property (p_active_set) else $error("active flag not set");

    property p_soft_break;
        @(posedge pclk) disable iff (!presetn)
        (soft_break && state_r == ST_IDLE && !addr_hit) |=> state_r == ST_PEND;
    endproperty
    a_soft_break: assert property (p_soft_break) else $error("soft break lost");

    property p_pend_start;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_PEND && cpu.insn_start) |-> breakpoint_request ##1 in_break;
    endproperty
    a_pend_start: assert property (p_pend_start) else $error("pending break not taken");

    property p_operand_defer;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && match_operand) |-> !breakpoint_request ##1 state_r == ST_PEND;
    endproperty
    a_operand_defer: assert property (p_operand_defer) else $error("operand break early");

    property p_timer_halt;
        @(posedge pclk) disable iff (!presetn)
        $rose(in_break) |-> timer_halt && $past(breakpoint_request);
    endproperty
    a_timer_halt: assert property (p_timer_halt) else $error("timer not halted");

    property p_wait_nomatch;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && (sys.in_wait || sys.in_stop) && !soft_break)
            |=> state_r == ST_IDLE;
    endproperty
    a_wait_nomatch: assert property (p_wait_nomatch) else $error("match in low power");

    property p_flag_protect;
        @(posedge pclk) disable iff (!presetn)
        (in_break && !flag_clear_in_break_enable_r) |-> !flag_clear_allowed;
    endproperty
    a_flag_protect: assert property (p_flag_protect) else $error("flags clearable");

    // a disarmed match must not break again until an address register is written
    property p_rearm;
        @(posedge pclk) disable iff (!presetn)
        addr_write |=> match_armed_r;
    endproperty
    a_rearm: assert property (p_rearm) else $error("address write did not rearm");

    property p_disarm_hold;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && !match_armed_r && !soft_break) |=> state_r == ST_IDLE;
    endproperty
    a_disarm_hold: assert property (p_disarm_hold) else $error("disarmed match broke");

    property p_fetch_only;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && !cpu.fetch && !soft_break) |=> state_r == ST_IDLE;
    endproperty
    a_fetch_only: assert property (p_fetch_only) else $error("data access broke");

    property p_request_pulse;
        @(posedge pclk) disable iff (!presetn)
        breakpoint_request |=> !breakpoint_request;
    endproperty
    a_request_pulse: assert property (p_request_pulse) else $error("request too long");

    property p_status_hold;
        @(posedge pclk) disable iff (!presetn)
        (in_break && !flag_clear_in_break_enable_r)
            |=> (irq_status_r & $past(irq_status_r)) == $past(irq_status_r);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("flag lost in break");

    property p_zero_clear;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_STATUS_CONTROL && !pwdata[BIT_ACTIVE] && !addr_hit)
            |=> !break_active_flag_r;
    endproperty
    a_zero_clear: assert property (p_zero_clear) else $error("active bit not cleared");

    property p_addr_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_ADDR_LOW) |=> break_address_low_r == $past(pwdata[7:0]);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("address not stored");

    property p_watchdog;
        @(posedge pclk) disable iff (!presetn)
        watchdog_hold |-> in_break && sys.monitor_mode;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog held outside break");

    property p_wait_exit;
        @(posedge pclk) disable iff (!presetn)
        (sys.wait_exit && in_break) |=> wait_exit_by_break_r;
    endproperty
    a_wait_exit: assert property (p_wait_exit) else $error("wait exit not flagged");

    c_opcode_break: cover property (@(posedge pclk) disable iff (!presetn)
        match_opcode ##1 in_break);
    c_soft_break: cover property (@(posedge pclk) disable iff (!presetn)
        soft_break ##[1:20] in_break);
    c_rti: cover property (@(posedge pclk) disable iff (!presetn)
        in_break ##1 sys.rti ##1 !in_break);
    c_operand_break: cover property (@(posedge pclk) disable iff (!presetn)
        match_operand ##1 state_r == ST_PEND);
endmodule

// ===== dv/breakpoint_request_cpu_model.sv
// partner model: cpu core and integration unit facing the breakpoint unit
`timescale 1ns/10ps
module bamu_cpu_model
    import bamu_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // from the unit
    input wire logic breakpoint_request,
    input wire logic in_break,
    // to the unit
    output bamu_cpu_t cpu,
    output bamu_sys_t sys
);
    int req_cnt;
    bamu_sys_t lv;
    initial
    begin
        cpu = '0;
        sys = '0;
        lv = '0;
    end
    // counting requests lets the bench see a one-cycle pulse without racing it
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            req_cnt <= 0;
        else if (breakpoint_request)
            req_cnt <= req_cnt + 1;
    // one bus cycle; released address is inverted so a stale match cannot linger
    task fetch(input logic [15:0] a, input logic f, input logic op);
        @(posedge pclk);
        cpu <= '{a, f, op, op};
        @(posedge pclk);
        cpu <= '{~a, 1'b0, 1'b0, 1'b0};
    endtask
    task levels(input bamu_sys_t s);
        @(posedge pclk);
        lv = s;
        sys <= s;
        @(negedge pclk);
    endtask
    // return pulse stands in for the software interrupt routine ending with its return
    task pulse(input bamu_sys_t s);
        @(posedge pclk);
        sys <= lv | s;
        @(posedge pclk);
        sys <= lv;
        @(negedge pclk);
    endtask
endmodule

// ===== dv/tb_breakpoint_request_unit.sv
// testbench: apb register access and break scenarios for the breakpoint unit
`timescale 1ns/10ps
module tb_bamu_unit
    import bamu_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, breakpoint_request, in_break, timer_halt, watchdog_hold;
    logic flag_clear_allowed, irq, err;
    bamu_cpu_t cpu;
    bamu_sys_t sys;
    int n_fail = 0, total_checks = 0, nreq = 0;
    always #12.5 pclk = ~pclk;
    bamu_unit u_bamu_unit (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu(cpu), .sys(sys),
        .breakpoint_request(breakpoint_request), .in_break(in_break),
        .timer_halt(timer_halt), .watchdog_hold(watchdog_hold),
        .flag_clear_allowed(flag_clear_allowed), .irq(irq)
    );
    bamu_cpu_model u_bamu_cpu_model (
        .pclk(pclk), .presetn(presetn), .breakpoint_request(breakpoint_request),
        .in_break(in_break), .cpu(cpu), .sys(sys)
    );
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    // settle on the falling edge so level outputs reflect the write
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        @(negedge pclk);
    endtask
    task breakpoint_unit(input int n);
        @(posedge pclk);
        nreq += n;
        chk(32'(u_bamu_cpu_model.req_cnt), 32'(nreq));
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_fail++;
        conclude();
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(12'(4 * i), 32'h0);
        rd(12'h020, 32'h0);
        chk(err, 1'b1);
        chk(flag_clear_allowed, 1'b1);
        $display("test reset done");
        wr(OFS_ADDR_HIGH, 8'h12);
        wr(OFS_ADDR_LOW, 8'h34);
        wr(OFS_STATUS_CONTROL, 8'h80);
        rd(OFS_ADDR_HIGH, 32'h12);
        rd(OFS_ADDR_LOW, 32'h34);
        rd(OFS_STATUS_CONTROL, 32'h80);
        u_bamu_cpu_model.fetch(16'h1234, 1'b0, 1'b0);
        breakpoint_unit(0);
        u_bamu_cpu_model.fetch(16'h1235, 1'b1, 1'b1);
        breakpoint_unit(0);
        u_bamu_cpu_model.levels('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
        u_bamu_cpu_model.fetch(16'h1234, 1'b1, 1'b1);
        breakpoint_unit(0);
        u_bamu_cpu_model.levels('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0});
        u_bamu_cpu_model.fetch(16'h1234, 1'b1, 1'b1);
        breakpoint_unit(0);
        u_bamu_cpu_model.levels('0);
        u_bamu_cpu_model.fetch(16'h1234, 1'b1, 1'b1);
        breakpoint_unit(1);
        chk(in_break, 1'b1);
        chk(timer_halt, 1'b1);
        rd(OFS_STATUS_CONTROL, 32'hC0);
        $display("test match done");
        u_bamu_cpu_model.levels('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
        chk(watchdog_hold, 1'b0);
        wr(OFS_AUXILIARY, 8'h01);
        chk(watchdog_hold, 1'b1);
        chk(flag_clear_allowed, 1'b0);
        wr(OFS_IRQ_STATUS, 8'h01);
        rd(OFS_IRQ_STATUS, 32'h1);
        wr(OFS_FLAG_CONTROL, 8'h80);
        chk(flag_clear_allowed, 1'b1);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 8'h03);
        chk(irq, 1'b1);
        wr(OFS_IRQ_STATUS, 8'h01);
        chk(irq, 1'b0);
        rd(OFS_IRQ_STATUS, 32'h0);
        u_bamu_cpu_model.levels('0);
        chk(watchdog_hold, 1'b0);
        $display("test controls done");
        wr(OFS_STATUS_CONTROL, 8'h80);
        rd(OFS_STATUS_CONTROL, 32'h80);
        u_bamu_cpu_model.pulse('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
        chk(in_break, 1'b0);
        u_bamu_cpu_model.fetch(16'h1234, 1'b1, 1'b1);
        breakpoint_unit(0);
        wr(OFS_ADDR_LOW, 8'h34);
        u_bamu_cpu_model.fetch(16'h1234, 1'b1, 1'b1);
        breakpoint_unit(1);
        wr(OFS_STATUS_CONTROL, 8'h80);
        u_bamu_cpu_model.pulse('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
        wr(OFS_ADDR_HIGH, 8'h12);
        u_bamu_cpu_model.fetch(16'h1234, 1'b1, 1'b0);
        breakpoint_unit(0);
        u_bamu_cpu_model.fetch(16'h1236, 1'b1, 1'b1);
        breakpoint_unit(1);
        wr(OFS_STATUS_CONTROL, 8'h80);
        u_bamu_cpu_model.pulse('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
        $display("test rearm done");
        wr(OFS_STATUS_CONTROL, 8'h40);
        breakpoint_unit(0);
        u_bamu_cpu_model.fetch(16'h3000, 1'b1, 1'b1);
        breakpoint_unit(1);
        rd(OFS_STATUS_CONTROL, 32'h40);
        rd(OFS_IRQ_STATUS, 32'h3);
        u_bamu_cpu_model.pulse('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
        rd(OFS_WAIT_STATUS, 32'h2);
        wr(OFS_STATUS_CONTROL, 8'h00);
        rd(OFS_STATUS_CONTROL, 32'h0);
        u_bamu_cpu_model.pulse('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
        rd(OFS_WAIT_STATUS, 32'h0);
        chk(timer_halt, 1'b0);
        $display("test soft break done");
        conclude();
    end
endmodule
